// ===== logic/mmd_flash_ctl.sv
// flash sector classification and erase timing
`timescale 1ns/10ps
`default_nettype none
module mmd_flash_ctl (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // link to decoder
  mmd_flash_if.ctl fl
);
  import mmd_pkg::*;
  logic [15:0] cnt_reg;
  assign fl.sector_ok = (fl.addr <= XSEC_HI) &&
                        !((fl.addr >= RSVD_LO) && (fl.addr <= RSVD_HI));
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= 16'h0000;
    end else if (cnt_reg != 16'h0000) begin
      cnt_reg <= cnt_reg - 16'h0001;
    end else if (fl.erase_req && fl.sector_ok) begin
      cnt_reg <= 16'(ERASE_CYC);
    end
  end
  assign fl.busy = (cnt_reg != 16'h0000);
endmodule : mmd_flash_ctl
`default_nettype wire

// ===== logic/mmd_flash_if.sv
// interface between decoder and flash sector controller
`timescale 1ns/10ps
`default_nettype none
interface mmd_flash_if;
  logic [15:0] addr;
  logic        erase_req;
  logic        sector_ok;
  logic        busy;
  modport ctl (input addr, input erase_req, output sector_ok, output busy);
  modport top (output addr, output erase_req, input sector_ok, input busy);
endinterface : mmd_flash_if
`default_nettype wire

// ===== logic/mmd_pkg.sv
// package of constants and types for the memory address decoder
// How it works
// - indirect upper-half data goes to RAM
// - direct upper-half data goes to register space
// - lower half always goes to RAM
// - first 32 bytes form four register banks
// - next 16 bytes are bit addressable
// - 2048-byte external block mirrors over 64k
// - flash erased in 512-byte sectors in-system
// - extra 128-byte sector at 0x8000 to 0x807F
package mmd_pkg;
  localparam int          DATA_W        = 8;
  localparam int          IADDR_W       = 8;
  localparam int          XADDR_W       = 16;
  localparam int          PADDR_W       = 16;
  localparam int          IRAM_DEPTH    = 256;
  localparam int          XRAM_DEPTH    = 2048;
  localparam int          XRAM_AW       = 11;
  localparam int          SECTOR_AW     = 9;
  localparam int          SECTOR_NUM_W  = 7;
  localparam int          SECTOR_BYTES  = 512;
  localparam int          XSEC_BYTES    = 128;
  localparam logic [7:0]  UPPER_BASE    = 8'h80;
  localparam logic [7:0]  BANK_END      = 8'h1F;
  localparam logic [7:0]  BIT_BASE      = 8'h20;
  localparam logic [7:0]  BIT_END       = 8'h2F;
  localparam logic [15:0] RSVD_LO       = 16'h7E00;
  localparam logic [15:0] RSVD_HI       = 16'h7FFF;
  localparam logic [15:0] XSEC_LO       = 16'h8000;
  localparam logic [15:0] XSEC_HI       = 16'h807F;
  localparam logic [15:0] MAIN_HI       = 16'h7FFF;
  localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
  // erase time in ns and derived cycles at 200 MHz
  localparam int          ERASE_NS      = 1000;
  localparam int          CLK_NS        = 5;
  localparam int          ERASE_CYC     = (ERASE_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {
    MMD_TGT_NONE,
    MMD_TGT_RAM,
    MMD_TGT_SPECIAL
  } mmd_target_t;
endpackage : mmd_pkg

// ===== logic/mmd_top.sv
// memory address decoder: internal, external and program spaces
`timescale 1ns/10ps
`default_nettype none
module mmd_top (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // internal data access
  input  wire logic                 i_req,
  input  wire logic                 i_we,
  input  wire logic                 i_indirect,
  input  wire logic [7:0]           i_addr,
  input  wire logic [7:0]           i_wdata,
  input  wire logic [1:0]           bank_sel,
  output var  logic [7:0]           i_rdata,
  output var  logic                 i_valid,
  output var  logic                 special_sel,
  output var  logic [7:0]           special_addr,
  // bit access in bit area
  input  wire logic                 b_req,
  input  wire logic                 b_we,
  input  wire logic [6:0]           b_addr,
  input  wire logic                 b_wdata,
  output var  logic                 b_rdata,
  // external data access
  input  wire logic                 x_req,
  input  wire logic                 x_we,
  input  wire logic [15:0]          x_addr,
  input  wire logic [7:0]           x_wdata,
  input  wire logic                 large_variant,
  output var  logic [7:0]           x_rdata,
  output var  logic                 x_valid,
  // program flash
  input  wire logic                 p_req,
  input  wire logic                 p_erase,
  input  wire logic                 p_we,
  input  wire logic [15:0]          p_addr,
  input  wire logic [7:0]           p_wdata,
  output var  logic [7:0]           p_rdata,
  output var  logic                 p_valid,
  output logic                      p_busy,
  output var  logic                 p_error
);
  import mmd_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // decode helpers
  // route by mode
  function automatic mmd_target_t route(input logic [7:0] a,
                                        input logic ind);
    if (a < UPPER_BASE) route = MMD_TGT_RAM; // lower half
    else if (ind)       route = MMD_TGT_RAM;
    else                route = MMD_TGT_SPECIAL; // direct upper
  endfunction : route

  function automatic logic [7:0] phys(input logic [7:0] a,
                                      input logic [1:0] bk);
    if (a <= BANK_END) phys = {3'b000, bk, a[2:0]};
    else               phys = a;
  endfunction : phys

  logic [7:0] iram [IRAM_DEPTH];
  logic [7:0] xram [XRAM_DEPTH];
  logic [7:0] flash [XSEC_HI + 1];
  mmd_target_t tgt;
  logic [7:0]  pa;
  logic [7:0]  bit_byte;
  logic [2:0]  bit_pos;
  mmd_flash_if fl ();

  // direct upper accesses bypass RAM so the core still reaches registers
  assign tgt      = route(i_addr, i_indirect);
  assign pa       = phys(i_addr, bank_sel);
  assign special_sel  = i_req && (tgt == MMD_TGT_SPECIAL);
  assign special_addr = i_addr;

  ////////////////////////////////////////////////////////////////////
  // internal RAM byte and bit ports
  // bit area address
  assign bit_byte = BIT_BASE + {4'h0, b_addr[6:3]};
  assign bit_pos  = b_addr[2:0];

  always_ff @(posedge clk) begin
    if (i_req && i_we && tgt == MMD_TGT_RAM) begin
      iram[pa] <= i_wdata;
    end else if (b_req && b_we) begin
      iram[bit_byte][bit_pos] <= b_wdata; // byte port wins a clash
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      i_rdata <= 8'h00;
      i_valid <= 1'b0;
      b_rdata <= 1'b0;
    end else begin
      i_valid <= i_req && (tgt == MMD_TGT_RAM);
      if (i_req && tgt == MMD_TGT_RAM) i_rdata <= iram[pa];
      if (b_req) b_rdata <= iram[bit_byte][bit_pos];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // external data block, aliased over 64k
  // mirror by low bits
  always_ff @(posedge clk) begin
    if (x_req && x_we && large_variant) begin
      xram[x_addr[XRAM_AW-1:0]] <= x_wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      x_rdata <= 8'h00;
      x_valid <= 1'b0;
    end else begin
      x_valid <= x_req && large_variant;
      x_rdata <= large_variant ? xram[x_addr[XRAM_AW-1:0]] : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // program flash: reads, byte program, sector erase
  assign fl.addr      = p_addr;
  assign fl.erase_req = p_req && p_erase && !fl.busy;
  assign p_busy       = fl.busy;

  mmd_flash_ctl u_fctl (
    .clk     (clk),
    .reset_n (reset_n),
    .fl      (fl)
  );

  // sector erase, no special supply; extra sector
  // programming only clears bits, as flash cells do
  always_ff @(posedge clk) begin
    if (fl.erase_req && fl.sector_ok) begin
      for (int i = 0; i < SECTOR_BYTES; i++) begin
        if (p_addr > MAIN_HI) begin
          if (i < XSEC_BYTES) flash[XSEC_LO + 16'(i)] <= ERASED_BYTE;
        end else begin
          flash[{p_addr[15:SECTOR_AW], 9'(i)}] <= ERASED_BYTE;
        end
      end
    end else if (p_req && p_we && !p_erase && !fl.busy && fl.sector_ok) begin
      flash[p_addr] <= flash[p_addr] & p_wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      p_rdata <= 8'h00;
      p_valid <= 1'b0;
      p_error <= 1'b0;
    end else begin
      p_valid <= p_req && !p_we && !p_erase && (p_addr <= XSEC_HI);
      p_error <= p_req && (p_we || p_erase) && (!fl.sector_ok || fl.busy);
      p_rdata <= (p_addr <= XSEC_HI) ? flash[p_addr] : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  AST_DIRECT_UPPER: assert property (@(posedge clk) disable iff (!reset_n)
    i_req && !i_indirect && i_addr[7] |-> special_sel)
    else $error("direct upper access not steered to registers");
  AST_INDIRECT_UPPER: assert property (@(posedge clk) disable iff (!reset_n)
    i_req && i_indirect && i_addr[7] |=> i_valid)
    else $error("indirect upper access not answered by RAM");
  AST_LOWER_RAM: assert property (@(posedge clk) disable iff (!reset_n)
    i_req && !i_addr[7] |-> !special_sel ##1 i_valid)
    else $error("lower half access left RAM");
  AST_BANK_MAP: assert property (@(posedge clk) disable iff (!reset_n)
    i_addr <= BANK_END |-> pa[7:3] == {3'b000, bank_sel})
    else $error("bank mapping wrong");
  AST_BIT_AREA: assert property (@(posedge clk) disable iff (!reset_n)
    b_req |-> bit_byte >= BIT_BASE && bit_byte <= BIT_END)
    else $error("bit access outside bit area");
  AST_XRAM_ALIAS: assert property (@(posedge clk) disable iff (!reset_n)
    x_req && large_variant |=> x_valid)
    else $error("external block not answered");
  AST_ERASE_BUSY: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(p_busy) |-> p_busy [*8])
    else $error("erase ended too early");
  AST_RSVD_REFUSED: assert property (@(posedge clk) disable iff (!reset_n)
    p_req && p_erase && p_addr >= RSVD_LO && p_addr <= RSVD_HI
    |=> p_error)
    else $error("reserved sector not refused");
  AST_XSEC_OK: assert property (@(posedge clk) disable iff (!reset_n)
    p_req && !p_we && !p_erase && p_addr >= XSEC_LO && p_addr <= XSEC_HI
    |=> p_valid)
    else $error("extra sector not readable");
  COV_SPECIAL: cover property (@(posedge clk) special_sel);
  COV_BIT: cover property (@(posedge clk) b_req && b_we);
  COV_ERASE: cover property (@(posedge clk) $rose(p_busy));
endmodule : mmd_top
`default_nettype wire

// ===== verif/mmd_core_model.sv
// core model issuing internal data accesses
`timescale 1ns/10ps
`default_nettype none
module mmd_core_model (
  // clock
  input  wire logic       clk,
  // request
  output logic            i_req,
  output logic            i_we,
  output logic            i_indirect,
  output logic [7:0]      i_addr,
  output logic [7:0]      i_wdata,
  // answer
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_valid,
  input  wire logic       special_sel,
  input  wire logic [7:0] special_addr
);
  // idle at time zero
  initial begin
    i_req = 1'b0;
    {i_we, i_indirect, i_addr, i_wdata} = '0;
  end
  task automatic iacc(input logic we, input logic ind, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] rd, output logic v,
      output logic s);
    @(posedge clk);
    #1;
    {i_req, i_we, i_indirect, i_addr, i_wdata} = {1'b1, we, ind, a, d};
    #1;
    // strobe only counts when the address passes through unchanged
    s = special_sel && (special_addr === a);
    @(posedge clk);
    #1;
    i_req = 1'b0;
    // released lines flip so a stale value cannot pass
    {i_indirect, i_addr, i_wdata} = {~ind, ~a, ~d};
    rd = i_rdata;
    v = i_valid;
  endtask : iacc
endmodule : mmd_core_model
`default_nettype wire

// ===== verif/tb_mcu_memory_address_decode.sv
// self-checking bench for the memory address decoder
`timescale 1ns/10ps
`default_nettype none
module tb_mcu_memory_address_decode;
  import mmd_pkg::*;
  logic        clk, reset_n, i_req, i_we, i_ind, i_valid, special_sel;
  logic [7:0]  i_addr, i_wdata, i_rdata, special_addr, x_wdata, x_rdata;
  logic [7:0]  p_wdata;
  logic [1:0]  bank_sel;
  logic        b_req, b_we, b_wdata, b_rdata, x_req, x_we, lv, x_valid;
  logic [6:0]  b_addr;
  logic [15:0] x_addr, p_addr, base[2], corner[3], pa;
  logic        p_req, p_erase, p_we, p_valid, p_busy, p_error, v, s;
  logic [7:0]  p_rdata, a, d, rd;
  int          errors, comparisons, n;
  mmd_top dut (.clk(clk), .reset_n(reset_n), .i_req(i_req), .i_we(i_we),
    .i_indirect(i_ind), .i_addr(i_addr), .i_wdata(i_wdata),
    .bank_sel(bank_sel), .i_rdata(i_rdata), .i_valid(i_valid),
    .special_sel(special_sel), .special_addr(special_addr),
    .b_req(b_req), .b_we(b_we),
    .b_addr(b_addr), .b_wdata(b_wdata), .b_rdata(b_rdata), .x_req(x_req),
    .x_we(x_we), .x_addr(x_addr), .x_wdata(x_wdata), .large_variant(lv),
    .x_rdata(x_rdata), .x_valid(x_valid), .p_req(p_req), .p_erase(p_erase),
    .p_we(p_we), .p_addr(p_addr), .p_wdata(p_wdata), .p_rdata(p_rdata),
    .p_valid(p_valid), .p_busy(p_busy), .p_error(p_error));
  mmd_core_model core (.clk(clk), .i_req(i_req), .i_we(i_we),
    .i_indirect(i_ind), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_rdata(i_rdata), .i_valid(i_valid), .special_sel(special_sel),
    .special_addr(special_addr));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1) begin
      errors++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : chk
  // refused flash write addresses
  function automatic logic perr(input logic [15:0] ad);
    return (ad >= RSVD_LO && ad <= RSVD_HI) || ad > XSEC_HI;
  endfunction : perr
  // one-cycle requests; released lines flip afterwards
  task automatic bacc(input logic we, input logic [6:0] ad, input logic dv);
    @(posedge clk);
    #1 {b_req, b_we, b_addr, b_wdata} = {1'b1, we, ad, dv};
    @(posedge clk);
    #1 {b_req, b_addr, b_wdata} = {1'b0, ~ad, ~dv};
  endtask : bacc
  task automatic xacc(input logic we, input logic [15:0] ad,
      input logic [7:0] dv);
    @(posedge clk);
    #1 {x_req, x_we, x_addr, x_wdata} = {1'b1, we, ad, dv};
    @(posedge clk);
    #1 {x_req, x_addr, x_wdata} = {1'b0, ~ad, ~dv};
  endtask : xacc
  task automatic pacc(input logic er, input logic we, input logic [15:0] ad,
      input logic [7:0] dv);
    @(posedge clk);
    #1 {p_req, p_erase, p_we, p_addr, p_wdata} = {1'b1, er, we, ad, dv};
    @(posedge clk);
    #1 {p_req, p_addr, p_wdata} = {1'b0, ~ad, ~dv};
  endtask : pacc
  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // watchdog well past the expected run
  initial begin
    #200000;
    errors++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {errors, comparisons, bank_sel, b_req, b_we, b_addr, b_wdata} = '0;
    {x_req, x_we, x_addr, x_wdata, p_req, p_erase, p_we, p_addr} = '0;
    {reset_n, p_wdata, lv} = {1'b0, 8'h00, 1'b1};
    base = '{16'h0200, 16'h8000};
    // each corner and the address just above it straddle a boundary
    corner = '{16'h7DFF, 16'h7FFF, 16'h807F};
    void'($urandom(32'h80A604E1));
    repeat (16) @(posedge clk);
    #1 reset_n = 1'b1;
    for (int k = 0; k < 40; k++) begin
      {a, d} = 16'($urandom);
      core.iacc(1'b1, a[7] | 1'($urandom), a, d, rd, v, s);
      core.iacc(1'b1, 1'b0, a | 8'h80, ~d, rd, v, s);
      chk(s === 1'b1 && v === 1'b0, "direct upper not steered");
      core.iacc(1'b0, a[7] | 1'($urandom), a, 8'h00, rd, v, s);
      chk(v === 1'b1 && rd === d && s === 1'b0, "ram readback");
    end
    for (int k = 0; k < 8; k++) begin
      bank_sel = 2'(k);
      core.iacc(k < 4, 1'($urandom), 8'h05, 8'h10 + 8'(k % 4), rd, v, s);
      if (k > 3) chk(rd === 8'h10 + 8'(k % 4), "bank mix");
    end
    a = 8'($urandom);
    core.iacc(1'b1, 1'b0, 8'h20 + 8'(a[6:3]), 8'h00, rd, v, s);
    bacc(1'b1, a[6:0], 1'b1);
    core.iacc(1'b0, 1'b0, 8'h20 + 8'(a[6:3]), 8'h00, rd, v, s);
    chk(rd === 8'h01 << a[2:0], "bit in byte");
    bacc(1'b0, a[6:0], 1'b0);
    chk(b_rdata === 1'b1, "bit read");
    // byte write and bit write in one cycle: the byte port wins
    fork
      core.iacc(1'b1, 1'b0, 8'h20 + 8'(a[6:3]), 8'h00, rd, v, s);
      bacc(1'b1, a[6:0], 1'b1);
    join
    core.iacc(1'b0, 1'b0, 8'h20 + 8'(a[6:3]), 8'h00, rd, v, s);
    chk(rd === 8'h00, "byte beats bit");
    for (int k = 0; k < 8; k++) begin
      {x_addr, d} = 24'($urandom);
      xacc(1'b1, x_addr, d);
      xacc(1'b0, {5'($urandom), ~x_addr[10:0]}, 8'h00);
      chk(x_valid === 1'b1 && x_rdata === d, "mirror");
    end
    lv = 1'b0;
    xacc(1'b0, 16'h0000, 8'h00);
    chk(x_valid === 1'b0 && x_rdata === 8'h00, "absent block");
    for (int k = 0; k < 2; k++) begin
      pa = base[k] + 16'($urandom % (k ? 128 : 512));
      pacc(1'b1, 1'b0, pa, 8'h00);
      for (n = 0; p_busy === 1'b1 && n < 1000; n++) @(posedge clk) #1;
      chk(n == ERASE_CYC, "erase length");
      pacc(1'b0, 1'b0, pa, 8'h00);
      chk(p_valid === 1'b1 && p_rdata === ERASED_BYTE, "erased");
      d = 8'($urandom);
      pacc(1'b0, 1'b1, pa, d);
      pacc(1'b0, 1'b0, pa, 8'h00);
      chk(p_rdata === d && p_error === 1'b0, "program");
    end
    foreach (corner[k]) begin
      pa = corner[k];
      pacc(1'b0, 1'b1, pa, 8'hFF);
      chk(p_error === perr(pa), "refusal");
      pacc(1'b0, 1'b1, pa + 16'h0001, 8'hFF);
      chk(p_error === perr(pa + 16'h0001), "refusal");
    end
    pacc(1'b1, 1'b0, 16'h0400, 8'h00);
    pacc(1'b0, 1'b1, 16'h1000, 8'h00);
    chk(p_error === 1'b1, "write while busy");
    for (n = 0; p_busy === 1'b1 && n < 1000; n++) @(posedge clk) #1;
    pacc(1'b1, 1'b0, 16'h7E00, 8'h00);
    chk(p_error === 1'b1 && p_busy === 1'b0, "reserved erase");
    summarize();
  end
endmodule : tb_mcu_memory_address_decode
`default_nettype wire
